// ===== bench/lim_leds.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// External indicator pads
// ----
module lim_leds (
	input wire logic aclk,
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	output logic [5:0] pad
);
	logic [5:0] last_ff = 6'h00;
	// Undriven pads have no pull, so they flip each cycle
	assign pad = (pin_oe & pin_out) | (~pin_oe & ~last_ff);
	always @(posedge aclk)
		last_ff <= pad;
endmodule
`default_nettype wire

// ===== bench/lim_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Bus and pin checker
// ----
module lim_top_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] pin_ibuf_en,
	input wire logic [5:0] pin_pullup_en
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	wr_answer_a: assert property (ce && $rose(s_axi_awvalid && s_axi_wvalid) && !s_axi_bvalid
		|-> ##1 (s_axi_awready && s_axi_wready) ##1 s_axi_bvalid) else $error("write answer late");
	rd_answer_a: assert property (ce && $rose(s_axi_arvalid) && !s_axi_rvalid
		|-> ##1 s_axi_arready ##1 s_axi_rvalid) else $error("read answer late");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready stuck");
	ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready stuck");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	rst_quiet_a: assert property ($rose(aresetn) |-> pin_oe == 6'h00 && !s_axi_bvalid)
		else $error("pins driven out of reset");
	pad_cfg_a: assert property (pin_ibuf_en == pin_pullup_en)
		else $error("input buffer and pull-up disagree");

	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(pin_oe[5]));
endmodule
`default_nettype wire

// ===== bench/lim_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "lim_map.vh"
// ----
// Bench top
// ----
module lim_top_tb;
	localparam logic [11:0] CFG = `LIM_OFS_LED_PIN_CONFIG;
	localparam logic [11:0] CTL = `LIM_OFS_LED_CONTROL;
	localparam logic [11:0] STS = `LIM_OFS_LED_STATUS;
	localparam logic [1:0] OK = `LIM_RESP_OKAY;
	localparam logic [1:0] ERR = `LIM_RESP_SLVERR;
	localparam logic [5:0] POL = 6'h21;
	localparam int SC = 8;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [2:0] link = 3'h0;
	logic [2:0] spd = 3'h0;
	logic [2:0] fdx = 3'h0;
	logic [2:0] col = 3'h0;
	logic [2:0] tx = 3'h0;
	logic [2:0] rx = 3'h0;
	logic [5:0] g_out = 6'h00;
	logic [5:0] g_oe = 6'h00;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [5:0] p_out, p_oe, ibuf, pull, pad;
	int failures = 0;
	int tests_run = 0;

	always #12.5 aclk = ~aclk;

	lim_top #(.STRETCH_CYC(22'h00_0008)) lim_top_inst (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.port_link(link), .port_speed100(spd), .port_full_duplex(fdx), .port_collision(col),
		.port_tx_en(tx), .port_rx_dv(rx), .strap_led_function_select(3'h4), .strap_led_pin_enable(6'h3f),
		.strap_led_pol(POL), .gpio_core_out(g_out), .gpio_core_oe(g_oe),
		.pin_out(p_out), .pin_oe(p_oe), .pin_ibuf_en(ibuf), .pin_pullup_en(pull)
	);
	lim_leds lim_leds_inst (.aclk(aclk), .pin_out(p_out), .pin_oe(p_oe), .pad(pad));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		begin
			tests_run++;
			if (s !== e)
			begin
				failures++;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask

	task automatic chk6(input logic [5:0] s, input logic [5:0] e);
		begin
			chk({26'h0, s}, {26'h0, e});
		end
	endtask

	// Bus write, held until awready
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			n = 0;
			do
			begin
				@(posedge aclk);
				n++;
			end
			while (awready !== 1'b1 && n < 50);
			awvalid <= 1'b0;
			wvalid <= 1'b0;
			while (bvalid !== 1'b1 && n < 50)
			begin
				@(posedge aclk);
				n++;
			end
			bready <= 1'b0;
			chk(n < 50, 1);
			chk(bresp, r);
		end
	endtask

	// Bus read, data taken at the rvalid edge
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			n = 0;
			do
			begin
				@(posedge aclk);
				n++;
			end
			while (arready !== 1'b1 && n < 50);
			arvalid <= 1'b0;
			while (rvalid !== 1'b1 && n < 50)
			begin
				@(posedge aclk);
				n++;
			end
			rready <= 1'b0;
			chk(n < 50, 1);
			chk(rdata, d);
			chk(rresp, r);
		end
	endtask

	// Open-drain pins: enable pattern, active level, input buffers and pull-ups off
	task automatic pins(input logic [5:0] e);
		begin
			repeat (3) @(posedge aclk);
			#1;
			chk6(p_oe, e);
			chk6(pad & e, ~POL & e);
			chk({20'h0, ibuf, pull}, 32'h0000_0000);
		end
	endtask

	task automatic t_reset;
		begin
			rd(CFG, 32'h0000_043f, OK);
			rd(12'h100, 32'h0000_0000, ERR);
			wr(12'h100, 32'hffff_ffff, ERR);
		end
	endtask

	task automatic t_link;
		begin
			@(posedge aclk);
			link <= 3'b110;
			fdx <= 3'b110;
			spd <= 3'b100;
			pins(6'h1b);
			@(posedge aclk);
			fdx <= 3'b010;
			pins(6'h13);
			@(posedge aclk);
			col <= 3'b100;
			@(posedge aclk);
			col <= 3'b000;
			pins(6'h1b);
			repeat (20) @(posedge aclk);
			fdx <= 3'b110;
			wr(CTL, 32'h0000_0002, OK);
			@(posedge aclk);
			rx <= 3'b001;
			@(posedge aclk);
			rx <= 3'b000;
			pins(6'h1b);
			wr(CTL, 32'h0000_0000, OK);
			repeat (20) @(posedge aclk);
		end
	endtask

	// Held traffic: pulse length, gap, then link gating
	task automatic t_act;
		int n;
		int h;
		int l;
		begin
			@(posedge aclk);
			tx <= 3'b100;
			n = 0;
			while (p_oe[5] !== 1'b1 && n < 10)
			begin
				@(posedge aclk);
				n++;
			end
			h = 0;
			while (p_oe[5] === 1'b1 && h < 40)
			begin
				@(posedge aclk);
				h++;
			end
			l = 0;
			while (p_oe[5] !== 1'b1 && l < 40)
			begin
				@(posedge aclk);
				l++;
			end
			chk(h, SC);
			chk((l >= SC) && (l < SC + 3), 1);
			link <= 3'b010;
			tx <= 3'b000;
			pins(6'h03);
			@(posedge aclk);
			link <= 3'b110;
			repeat (20) @(posedge aclk);
		end
	endtask

	task automatic t_raw;
		begin
			wr(CFG, 32'h0000_073f, OK);
			@(posedge aclk);
			tx <= 3'b001;
			rx <= 3'b010;
			repeat (3) @(posedge aclk);
			#1;
			chk6(p_oe, 6'h3f);
			chk6(p_out, 6'h21);
			wr(CTL, 32'h0000_0001, OK);
			repeat (3) @(posedge aclk);
			#1;
			chk6(p_out, 6'h00);
			chk6(p_oe, 6'h3f);
			wr(CFG, 32'h0000_043f, OK);
			repeat (3) @(posedge aclk);
			#1;
			chk6(p_oe, 6'h00);
			wr(CTL, 32'h0000_0000, OK);
			tx <= 3'b000;
			rx <= 3'b000;
			repeat (20) @(posedge aclk);
		end
	endtask

	task automatic t_speed;
		begin
			wr(CFG, 32'h0000_053f, OK);
			link <= 3'b111;
			pins(6'h0a);
			wr(CFG, 32'h0000_063f, OK);
			pins(6'h00);
		end
	endtask

	task automatic t_gpio;
		begin
			@(posedge aclk);
			g_out <= 6'h2a;
			g_oe <= 6'h0f;
			wr(CFG, 32'h0000_0400, OK);
			repeat (3) @(posedge aclk);
			#1;
			chk6(p_oe, 6'h0f);
			chk6(p_out & 6'h0f, 6'h0a);
			chk({20'h0, ibuf, pull}, 32'h0000_0fff);
			rd(CFG, 32'h0000_0400, OK);
		end
	endtask

	// Status word: port-0 stretched pulses survive a clock-enable freeze
	task automatic t_status;
		begin
			@(posedge aclk);
			tx <= 3'b001;
			rx <= 3'b001;
			@(posedge aclk);
			tx <= 3'b000;
			rx <= 3'b000;
			ce <= 1'b0;
			repeat (20) @(posedge aclk);
			ce <= 1'b1;
			rd(STS, 32'h1b21_0a1b, OK);
			repeat (20) @(posedge aclk);
			rd(STS, 32'h1c21_0a1b, OK);
		end
	endtask

	task automatic conclude;
		begin
			$display("checks=%0d failures=%0d", tests_run, failures);
			if (failures == 0 && tests_run > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask

	// Main sequence
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_link();
		t_act();
		t_raw();
		t_speed();
		t_gpio();
		t_status();
		conclude();
	end

	// Watchdog
	initial
	begin
		#100000;
		failures++;
		conclude();
	end
endmodule

bind lim_top lim_top_sva lim_top_sva_inst (
	.aclk(aclk), .aresetn(aresetn), .ce(ce),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.pin_oe(pin_oe), .pin_ibuf_en(pin_ibuf_en), .pin_pullup_en(pin_pullup_en)
);
`default_nettype wire

// ===== hdl/lim_map.vh
`ifndef LIM_MAP_VH
`define LIM_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LIM_OFS_LED_PIN_CONFIG 12'h1bc
`define LIM_OFS_LED_CONTROL 12'h1c0
`define LIM_OFS_LED_STATUS 12'h1c4
`define LIM_OFS_PIN_IO_CONFIG 12'h1e0
`define LIM_OFS_PIN_DATA_DIRECTION 12'h1e4
`define LIM_OFS_PIN_IRQ_STATUS_ENABLE 12'h1e8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LIM_CFG_EN_LSB 0
`define LIM_CFG_FUN_LSB 8
`define LIM_CTL_DIS_BIT 0
`define LIM_CTL_P1OFF_BIT 1
`define LIM_STS_IND_LSB 0
`define LIM_STS_PIN_LSB 8
`define LIM_STS_POL_LSB 16
`define LIM_STS_TX0_BIT 24
`define LIM_STS_RX0_BIT 25
`define LIM_STS_LACT_LSB 26

// ----------------------------------------
// Function codes and reset values
// ----------------------------------------
`define LIM_FUN_PORT_LINK 3'h4
`define LIM_FUN_SPEED_LINK 3'h5
`define LIM_FUN_RESERVED 3'h6
`define LIM_FUN_RAW 3'h7
`define LIM_RST_WORD 32'h0000_0000
`define LIM_RESP_OKAY 2'h0
`define LIM_RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define LIM_STRETCH_MS 80
`define LIM_CLK_HZ 40000000
// 80 ms of 40 MHz clock cycles, sized to the counter width
`define LIM_STRETCH_CYC 22'h30_d400
`define LIM_CNT_W 22

`endif

// ===== hdl/lim_top.v
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "lim_map.vh"

// ----------------------------------------
// Pulse stretcher: on interval then gap
// ----------------------------------------
module lim_stretch #(
	parameter CNT_W = `LIM_CNT_W,
	parameter [CNT_W-1:0] TERM = `LIM_STRETCH_CYC
)(
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire trig,
	output reg pulse_ff
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ON = 2'h1;
	localparam [1:0] ST_GAP = 2'h2;
	localparam [CNT_W-1:0] LAST = TERM - 1'b1;
	reg [1:0] state_ff;
	reg [CNT_W-1:0] cnt_ff;
	reg [1:0] nxt_state;
	reg [CNT_W-1:0] nxt_cnt;

	// Next state: pulse for TERM cycles, then hold off for TERM
	always @*
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ST_IDLE:
			begin
				nxt_cnt = {CNT_W{1'b0}};
				if (trig)
					nxt_state = ST_ON;
			end
			ST_ON, ST_GAP:
			begin
				if (cnt_ff == LAST)
				begin
					nxt_cnt = {CNT_W{1'b0}};
					nxt_state = (state_ff == ST_ON) ? ST_GAP : ST_IDLE;
				end
				else
					nxt_cnt = cnt_ff + 1'b1;
			end
			default:
			begin
				nxt_state = ST_IDLE;
				nxt_cnt = {CNT_W{1'b0}};
			end
		endcase
	end

	// State registers
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= ST_IDLE;
			cnt_ff <= {CNT_W{1'b0}};
			pulse_ff <= 1'b0;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			pulse_ff <= (nxt_state == ST_ON);
		end
	end
endmodule

// ----------------------------------------
// LED indicator multiplexer top
// ----------------------------------------
module lim_top #(
	parameter CNT_W = `LIM_CNT_W,
	parameter [CNT_W-1:0] STRETCH_CYC = `LIM_STRETCH_CYC
)(
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [2:0] port_link,
	input wire [2:0] port_speed100,
	input wire [2:0] port_full_duplex,
	input wire [2:0] port_collision,
	input wire [2:0] port_tx_en,
	input wire [2:0] port_rx_dv,
	input wire [2:0] strap_led_function_select,
	input wire [5:0] strap_led_pin_enable,
	input wire [5:0] strap_led_pol,
	input wire [5:0] gpio_core_out,
	input wire [5:0] gpio_core_oe,
	output reg [5:0] pin_out,
	output reg [5:0] pin_oe,
	output reg [5:0] pin_ibuf_en,
	output reg [5:0] pin_pullup_en
);
	reg [14:0] strap_s1_ff;
	reg [14:0] strap_s2_ff;
	reg load_ff;
	reg [5:0] led_pin_enable_ff;
	reg [2:0] led_function_select_ff;
	reg [5:0] pol_ff;
	reg led_global_disable_ff;
	reg p1_off_ff;
	reg [31:0] io_cfg_ff;
	reg [31:0] data_dir_ff;
	reg [5:0] ind;
	reg [5:0] nxt_out;
	reg [5:0] nxt_oe;
	reg [31:0] rd_word;
	reg rd_hit;
	integer i;
	wire [2:0] act_ok;
	wire [2:0] act_s;
	wire [2:0] col_s;
	wire [2:0] act_ind;
	wire [2:0] dupcol;
	wire [2:0] speed;
	wire [2:0] fast_link;
	wire [2:0] slow_link;
	wire [2:0] link_act;
	wire [2:0] fast_link_act;
	wire [2:0] slow_link_act;
	wire tx0_s;
	wire rx0_s;
	wire wr_go;
	wire wr_hit;

	// ----------------------------------------
	// Strap synchronisers
	// ----------------------------------------

	// Two-stage sampling of strap pins
	always @(posedge aclk)
	begin
		if (ce)
		begin
			strap_s1_ff <= {strap_led_pol, strap_led_pin_enable, strap_led_function_select};
			strap_s2_ff <= strap_s1_ff;
		end
	end

	// ----------------------------------------
	// Indication sources
	// ----------------------------------------

	// Only internal PHY ports gate activity by link
	assign act_ok = {port_link[2], p1_off_ff | port_link[1], 1'b1};

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : g_port
			lim_stretch #(.CNT_W(CNT_W), .TERM(STRETCH_CYC)) u_act (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.trig((port_tx_en[g] | port_rx_dv[g]) & act_ok[g]),
				.pulse_ff(act_s[g])
			);
			lim_stretch #(.CNT_W(CNT_W), .TERM(STRETCH_CYC)) u_col (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.trig(port_collision[g] & port_link[g] & ~port_full_duplex[g]),
				.pulse_ff(col_s[g])
			);
		end
	endgenerate

	// Port 0 transmit and receive stretchers
	lim_stretch #(.CNT_W(CNT_W), .TERM(STRETCH_CYC)) u_tx0 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.trig(port_tx_en[0]),
		.pulse_ff(tx0_s)
	);
	lim_stretch #(.CNT_W(CNT_W), .TERM(STRETCH_CYC)) u_rx0 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.trig(port_rx_dv[0]),
		.pulse_ff(rx0_s)
	);

	// Per-port indication types
	assign act_ind = act_s & act_ok;
	assign dupcol = port_link & (port_full_duplex | col_s);
	assign speed = port_link & port_speed100;
	assign fast_link = port_link & port_speed100;
	assign slow_link = port_link & ~port_speed100;
	assign link_act = port_link & ~act_s;
	assign fast_link_act = fast_link & ~act_s;
	assign slow_link_act = slow_link & ~act_s;

	// Function-select mapping onto the six pins
	always @*
	begin
		case (led_function_select_ff)
			`LIM_FUN_PORT_LINK:
				ind = {act_ind[2], port_link[2], dupcol[2], act_ind[1],
					p1_off_ff ? speed[2] : port_link[1],
					p1_off_ff ? act_ind[0] : dupcol[1]};
			`LIM_FUN_SPEED_LINK:
				ind = {act_ind[2], slow_link[2], fast_link[2], act_ind[1],
					p1_off_ff ? dupcol[2] : slow_link[1],
					p1_off_ff ? act_ind[0] : fast_link[1]};
			`LIM_FUN_RAW:
				ind = {port_tx_en[0], port_tx_en[2], port_rx_dv[2],
					port_rx_dv[0], port_tx_en[1], port_rx_dv[1]};
			default:
				ind = 6'h00;
		endcase
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------

	// Per-pin output value and enable
	always @*
	begin
		for (i = 0; i < 6; i = i + 1)
		begin
			if (!led_pin_enable_ff[i])
			begin
				nxt_out[i] = gpio_core_out[i];
				nxt_oe[i] = gpio_core_oe[i];
			end
			else if (led_function_select_ff == `LIM_FUN_RAW)
			begin
				nxt_out[i] = ind[i] & ~led_global_disable_ff;
				nxt_oe[i] = 1'b1;
			end
			else
			begin
				nxt_out[i] = ~pol_ff[i];
				nxt_oe[i] = ind[i] & ~led_global_disable_ff;
			end
		end
	end

	// Registered pin outputs
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_out <= 6'h00;
			pin_oe <= 6'h00;
			pin_ibuf_en <= 6'h00;
			pin_pullup_en <= 6'h00;
		end
		else if (ce)
		begin
			pin_out <= nxt_out;
			pin_oe <= nxt_oe;
			pin_ibuf_en <= ~led_pin_enable_ff;
			pin_pullup_en <= ~led_pin_enable_ff;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------

	// Byte-lane merge of write data
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] d;
		input [3:0] s;
		integer k;
		begin
			for (k = 0; k < 32; k = k + 1)
				wmerge[k] = s[k / 8] ? d[k] : old[k];
		end
	endfunction

	assign wr_go = s_axi_awvalid & s_axi_awready;
	assign wr_hit = (s_axi_awaddr == `LIM_OFS_LED_PIN_CONFIG) ||
		(s_axi_awaddr == `LIM_OFS_LED_CONTROL) ||
		(s_axi_awaddr == `LIM_OFS_LED_STATUS) ||
		(s_axi_awaddr == `LIM_OFS_PIN_IO_CONFIG) ||
		(s_axi_awaddr == `LIM_OFS_PIN_DATA_DIRECTION) ||
		(s_axi_awaddr == `LIM_OFS_PIN_IRQ_STATUS_ENABLE);

	// Write channels: take address and data together, then respond
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LIM_RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_awready <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
			s_axi_wready <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `LIM_RESP_OKAY : `LIM_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Configuration registers, strap load after reset release
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			load_ff <= 1'b1;
			led_pin_enable_ff <= 6'h00;
			led_function_select_ff <= 3'h0;
			pol_ff <= 6'h00;
			led_global_disable_ff <= 1'b0;
			p1_off_ff <= 1'b0;
			io_cfg_ff <= `LIM_RST_WORD;
			data_dir_ff <= `LIM_RST_WORD;
		end
		else if (ce)
		begin
			if (load_ff)
			begin
				load_ff <= 1'b0;
				led_function_select_ff <= strap_s2_ff[2:0];
				led_pin_enable_ff <= strap_s2_ff[8:3];
				pol_ff <= strap_s2_ff[14:9];
			end
			else if (wr_go)
			begin
				case (s_axi_awaddr)
					`LIM_OFS_LED_PIN_CONFIG:
					begin
						if (s_axi_wstrb[0])
							led_pin_enable_ff <= s_axi_wdata[`LIM_CFG_EN_LSB +: 6];
						if (s_axi_wstrb[1])
							led_function_select_ff <= s_axi_wdata[`LIM_CFG_FUN_LSB +: 3];
					end
					`LIM_OFS_LED_CONTROL:
					begin
						if (s_axi_wstrb[0])
						begin
							led_global_disable_ff <= s_axi_wdata[`LIM_CTL_DIS_BIT];
							p1_off_ff <= s_axi_wdata[`LIM_CTL_P1OFF_BIT];
						end
					end
					`LIM_OFS_PIN_IO_CONFIG:
						io_cfg_ff <= wmerge(io_cfg_ff, s_axi_wdata, s_axi_wstrb);
					`LIM_OFS_PIN_DATA_DIRECTION:
						data_dir_ff <= wmerge(data_dir_ff, s_axi_wdata, s_axi_wstrb);
					default:
						io_cfg_ff <= io_cfg_ff;
				endcase
			end
		end
	end

	// Read decode
	always @*
	begin
		rd_word = `LIM_RST_WORD;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`LIM_OFS_LED_PIN_CONFIG:
			begin
				rd_word[`LIM_CFG_EN_LSB +: 6] = led_pin_enable_ff;
				rd_word[`LIM_CFG_FUN_LSB +: 3] = led_function_select_ff;
			end
			`LIM_OFS_LED_CONTROL:
			begin
				rd_word[`LIM_CTL_DIS_BIT] = led_global_disable_ff;
				rd_word[`LIM_CTL_P1OFF_BIT] = p1_off_ff;
			end
			`LIM_OFS_LED_STATUS:
			begin
				rd_word[`LIM_STS_IND_LSB +: 6] = ind;
				rd_word[`LIM_STS_PIN_LSB +: 6] = pin_out & pin_oe;
				rd_word[`LIM_STS_POL_LSB +: 6] = pol_ff;
				rd_word[`LIM_STS_TX0_BIT] = tx0_s;
				rd_word[`LIM_STS_RX0_BIT] = rx0_s;
				rd_word[`LIM_STS_LACT_LSB +: 3] = link_act;
			end
			`LIM_OFS_PIN_IO_CONFIG:
				rd_word = io_cfg_ff;
			`LIM_OFS_PIN_DATA_DIRECTION:
				rd_word = data_dir_ff;
			`LIM_OFS_PIN_IRQ_STATUS_ENABLE:
				rd_word = `LIM_RST_WORD;
			default:
				rd_hit = 1'b0;
		endcase
	end

	// Read channel: one read at a time
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `LIM_RST_WORD;
			s_axi_rresp <= `LIM_RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? `LIM_RESP_OKAY : `LIM_RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule

`default_nettype wire
